// [common/jcr_defs.vh]
// Constants for the jumperless configuration register block.
`ifndef JCR_DEFS_VH
`define JCR_DEFS_VH
`define JCR_CLK_MHZ          250
`define JCR_POR_MIN_US       415
`define JCR_POR_CYCLES       (`JCR_POR_MIN_US * `JCR_CLK_MHZ)
`define JCR_JLESS_ADDR       10'h278
`define JCR_JLESS_WRITES     3'h4
`define JCR_ADDR_A           4'h0
`define JCR_ADDR_B           4'h1
`define JCR_ADDR_C           4'h2
`define JCR_A_IOBASE_LSB     0
`define JCR_IOSEL_SOFT       3'h1
`define JCR_B_MEDIA_LSB      0
`define JCR_MEDIA_TP         2'h0
`define JCR_MEDIA_AUI        2'h1
`define JCR_MEDIA_THIN       2'h2
`define JCR_B_ROMWE_BIT      5
`define JCR_B_NOEE_BIT       7
`define JCR_C_ROMBASE_LSB    0
`define JCR_C_ROMSIZE_LSB    3
`define JCR_C_ROMEN_BIT      5
`define JCR_C_NOSW_BIT       7
`define JCR_ROM_BASE0        20'h0C000
`define JCR_ROM_STEP         20'h00400
`endif

// [hw/jcr_config_regs.v]
// Power-on configuration registers with jumperless I/O base unlock and boot ROM decode.
`timescale 1ns/1ps
`include "jcr_defs.vh"
// Functional notes
// - Valid power-on reset loads registers A, B and C from straps.
// - Software may rewrite A and B; C changes only after reset, from straps or serial ROM data.
// - I/O base choices: software option plus seven fixed bases.
// - Boot ROM disabled or eight 1k-step bases, size none/16k/32k/64k.
// - Boot ROM base and size come from register C.
// - B bit 7 set blocks serial ROM configuration overwrite.
// - C bit 7 set disables all software configuration writes.
// - Software I/O option maps register A at address 278H.
// - Jumperless unlock honoured once per power-up.
// - Hardware reset reloads ROM config from serial ROM data.
// - Register B field selects twisted pair, AUI or thin coax.
// - Thin coax output shows thin medium is selected.
// - Device is idle in low power; software reinitialises afterwards. Code only blocks direct A/B writes and sets o_bus_outputs_disabled.
// - ROM window access asserts chip select and buffers data.
// - Register B write enable forwards or blocks ROM writes.
// - ROM data path is byte wide.
// - Reset held at least 415 us counts as valid power-on reset.
// - Unconnected straps read zero through pull-downs during reset.
// - Serial ROM select high overwrites strap configuration with ROM data.
module jcr_config_regs #(
  parameter POR_CYCLES = `JCR_POR_CYCLES
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Configuration straps and serial ROM configuration
  input  wire [7:0]  i_strap_a,
  input  wire [7:0]  i_strap_b,
  input  wire [7:0]  i_strap_c,
  input  wire        i_serial_rom_config_select,
  input  wire        i_ee_valid,
  input  wire [7:0]  i_ee_cfg_a,
  input  wire [7:0]  i_ee_cfg_b,
  input  wire [7:0]  i_ee_cfg_c,
  // Host I/O port
  input  wire [9:0]  i_io_addr,
  input  wire [7:0]  i_io_wdata,
  input  wire        i_io_wr,
  input  wire        i_io_rd,
  input  wire [9:0]  i_io_base,
  output reg  [7:0]  o_io_rdata,
  // Host memory cycle to boot ROM
  input  wire [19:0] i_mem_addr,
  input  wire        i_mem_rd,
  input  wire        i_mem_wr,
  input  wire [7:0]  i_isa_wdata,
  output wire [7:0]  o_isa_rdata,
  output wire        o_isa_rdata_oe,
  // Memory support data bus
  input  wire [7:0]  i_msd,
  output wire [7:0]  o_msd,
  output wire        o_msd_oe,
  output wire        o_strap_pulldown_en,
  output wire        o_rom_cs,
  output wire        o_rom_we,
  // Media and power
  input  wire        i_low_power_request,
  output wire [1:0]  o_media_sel,
  output wire        o_thin,
  output wire        o_bus_outputs_disabled,
  output wire [7:0]  o_cfg_a,
  output wire [7:0]  o_cfg_b,
  output wire [7:0]  o_cfg_c
);

  reg  [7:0]  cfg_a_r;
  reg  [7:0]  cfg_b_r;
  reg  [7:0]  cfg_c_r;
  reg  [31:0] rst_cnt_r;
  reg         strap_load_window_r;
  reg         in_reset_r;
  reg         ee_pend_r;
  reg  [2:0]  jl_cnt_r;
  reg         jl_used_r;

  wire        por_long = (rst_cnt_r >= POR_CYCLES - 1);
  wire        sw_lock = cfg_c_r[`JCR_C_NOSW_BIT];
  wire        soft_io = (cfg_a_r[2:0] == `JCR_IOSEL_SOFT) && !jl_used_r;
  wire        jl_hit = i_io_wr && soft_io && (i_io_addr == `JCR_JLESS_ADDR);
  wire        any_acc = i_io_wr | i_io_rd | i_mem_rd | i_mem_wr;
  wire [3:0]  reg_off = i_io_addr[3:0];
  wire        in_base = (i_io_addr[9:4] == i_io_base[9:4]);

  // Reset duration timing and strap load window.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_reset_r <= 1'b1;
      if (!por_long) begin
        rst_cnt_r <= rst_cnt_r + 32'h00000001;
      end
      if (por_long) begin
        strap_load_window_r <= 1'b1;
      end
    end else begin
      in_reset_r <= 1'b0;
      rst_cnt_r <= 32'h00000000;
      strap_load_window_r <= 1'b0;
    end
  end

  // Configuration registers, straps, serial ROM overwrite and jumperless unlock.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      jl_cnt_r <= 3'h0;
      ee_pend_r <= 1'b1;
      if (por_long) begin
        jl_used_r <= 1'b0;
      end
    end else begin
      if (in_reset_r && strap_load_window_r) begin
        cfg_a_r <= i_strap_a;
        cfg_b_r <= i_strap_b;
        cfg_c_r <= i_strap_c;
        ee_pend_r <= 1'b1;
      end else if (ee_pend_r && i_ee_valid) begin
        ee_pend_r <= 1'b0;
        if (i_serial_rom_config_select && !cfg_b_r[`JCR_B_NOEE_BIT]) begin
          cfg_a_r <= i_ee_cfg_a;
          cfg_b_r <= i_ee_cfg_b;
          cfg_c_r <= i_ee_cfg_c;
        end
      end else if (jl_hit && !sw_lock) begin
        if (jl_cnt_r == `JCR_JLESS_WRITES - 3'h1) begin
          cfg_a_r <= i_io_wdata;
          jl_used_r <= 1'b1;
          jl_cnt_r <= 3'h0;
        end else begin
          jl_cnt_r <= jl_cnt_r + 3'h1;
        end
      end else begin
        if (any_acc) begin
          jl_cnt_r <= 3'h0;
        end
        if (i_io_wr && in_base && !sw_lock && !i_low_power_request) begin
          if (reg_off == `JCR_ADDR_A) begin
            cfg_a_r <= i_io_wdata;
          end
          if (reg_off == `JCR_ADDR_B) begin
            cfg_b_r <= i_io_wdata;
          end
        end
      end
    end
  end

  // Register read port, data valid one cycle after the strobe.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd && in_base) begin
      case (reg_off)
        `JCR_ADDR_A: o_io_rdata <= cfg_a_r;
        `JCR_ADDR_B: o_io_rdata <= cfg_b_r;
        `JCR_ADDR_C: o_io_rdata <= cfg_c_r;
        default:     o_io_rdata <= 8'h00;
      endcase
    end else if (i_io_rd && soft_io && i_io_addr == `JCR_JLESS_ADDR) begin
      o_io_rdata <= cfg_a_r;
    end else begin
      o_io_rdata <= 8'h00;
    end
  end

  // Boot ROM window decode: base in 1k steps, size from C.
  wire [2:0]  rom_base_sel = cfg_c_r[`JCR_C_ROMBASE_LSB +: 3];
  wire [1:0]  rom_size_sel = cfg_c_r[`JCR_C_ROMSIZE_LSB +: 2];
  wire        rom_en = cfg_c_r[`JCR_C_ROMEN_BIT] && (rom_size_sel != 2'h0);
  wire [19:0] rom_base = `JCR_ROM_BASE0 + ({17'h00000, rom_base_sel} * `JCR_ROM_STEP);
  reg  [19:0] rom_len;
  always @* begin
    case (rom_size_sel)
      2'h1:    rom_len = 20'h04000;
      2'h2:    rom_len = 20'h08000;
      2'h3:    rom_len = 20'h10000;
      default: rom_len = 20'h00000;
    endcase
  end
  wire        rom_hit = rom_en && (i_mem_addr >= rom_base) &&
                        (i_mem_addr < rom_base + rom_len) && !in_reset_r;
  wire        rom_we_ok = cfg_b_r[`JCR_B_ROMWE_BIT];

  assign o_rom_cs       = rom_hit && (i_mem_rd || (i_mem_wr && rom_we_ok));
  assign o_rom_we       = rom_hit && i_mem_wr && rom_we_ok;
  assign o_isa_rdata    = i_msd;
  assign o_isa_rdata_oe = rom_hit && i_mem_rd;
  assign o_msd          = i_isa_wdata;
  assign o_msd_oe       = o_rom_we;
  assign o_strap_pulldown_en    = in_reset_r | strap_load_window_r;
  assign o_bus_outputs_disabled = in_reset_r | i_low_power_request;
  assign o_media_sel    = cfg_b_r[`JCR_B_MEDIA_LSB +: 2];
  assign o_thin         = (o_media_sel == `JCR_MEDIA_THIN);
  assign o_cfg_a        = cfg_a_r;
  assign o_cfg_b        = cfg_b_r;
  assign o_cfg_c        = cfg_c_r;

endmodule

// [testbench/jcr_far_model.sv]
// Far side: serial ROM configuration words and a byte-wide boot ROM.
`timescale 1ns/1ps
module jcr_far_model #(parameter [7:0] EE_A = 8'h00, EE_B = 8'h00, EE_C = 8'h00) (
  input  wire i_clk, i_rst_n, i_cs, i_drv, input wire [7:0] i_addr,
  output reg  o_ee_valid, output wire [23:0] o_ee_cfg, output wire [7:0] o_msd);
  reg       seen_r;
  reg [7:0] last_r;
  assign o_ee_cfg = {EE_C, EE_B, EE_A};
  // An idle ROM shows a byte that flips every cycle out of reset; in reset it holds FFh.
  assign o_msd = (i_cs && !i_drv) ? i_addr ^ 8'h5A : ~last_r;
  always @(posedge i_clk) begin
    o_ee_valid <= i_rst_n && !seen_r;
    seen_r     <= i_rst_n;
    last_r     <= i_rst_n ? o_msd : 8'h00;
  end
endmodule

// [testbench/jcr_config_regs_chk.sv]
// Concurrent checks on the ports of the configuration register block.
`timescale 1ns/1ps
module jcr_config_regs_chk (
  input wire        i_clk, i_rst_n, i_io_wr, i_ee_valid, i_low_power_request, i_mem_rd,
  input wire        i_mem_wr, o_rom_cs, o_rom_we, o_thin, o_bus_outputs_disabled,
  input wire        o_strap_pulldown_en,
  input wire [1:0]  o_media_sel,
  input wire [9:0]  i_io_addr, i_io_base,
  input wire [7:0]  i_io_wdata, i_msd, o_isa_rdata, o_cfg_b, o_cfg_c,
  input wire [19:0] i_mem_addr);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire [19:0] rom_off = i_mem_addr - 20'h0C000 - {7'h00, o_cfg_c[2:0], 10'h000};
  wire [19:0] rom_len = 20'h02000 << o_cfg_c[4:3];
  sequence s_wr(logic [3:0] off);
    i_io_wr && !i_ee_valid && i_io_addr == {i_io_base[9:4], off} && $past(i_rst_n);
  endsequence
  a_b_write: assert property (
    s_wr(4'h1) |=> o_cfg_b == (($past(o_cfg_c[7]) || $past(i_low_power_request)) ?
    $past(o_cfg_b) : $past(i_io_wdata))) else $error("B write wrong");
  a_c_fixed: assert property (
    s_wr(4'h2) |=> $stable(o_cfg_c)) else $error("C changed by write");
  a_rom_window: assert property (
    o_rom_cs |-> (i_mem_rd || i_mem_wr) && o_cfg_c[5] && o_cfg_c[4:3] != 2'h0 &&
    rom_off < rom_len) else $error("ROM select outside window");
  a_rom_write: assert property (
    o_rom_we |-> o_rom_cs && i_mem_wr && o_cfg_b[5]) else $error("ROM write not enabled");
  a_isa_path: assert property (
    o_rom_cs && i_mem_rd |-> o_isa_rdata == i_msd) else $error("ROM data not passed");
  a_media_thin: assert property (
    o_media_sel == o_cfg_b[1:0] && o_thin == (o_media_sel == 2'h2)) else $error("media");
  a_pulldown_on: assert property (
    @(posedge i_clk) disable iff (1'b0) !i_rst_n ##1 !i_rst_n |-> o_strap_pulldown_en)
    else $error("pull-downs off in reset");
  a_low_power_request_off: assert property (
    i_low_power_request [*2] |-> o_bus_outputs_disabled) else $error("outputs on");
endmodule
bind jcr_config_regs jcr_config_regs_chk u_chk (.*);

// [testbench/test_jumperless_config_regs.sv]
// Self-checking bench for the configuration register block.
`timescale 1ns/1ps
module test_jumperless_config_regs;
  localparam [7:0] EA = 8'h01, EB = 8'h22, EC = 8'h2B;
  // Reset starts released for one edge so the reset-length counter starts from a known zero.
  reg        clk = 0, rst_n = 1, sel = 1, iow = 0, ior = 0, mr = 0, mw = 0, lp = 0;
  reg [7:0]  sa = 8'h01, sb = 8'h80, sc = 8'h2A, wd = 8'h00;
  reg [9:0]  ioa = 10'h000;
  reg [19:0] ma = 20'h00000;
  wire [7:0] rdat, isad, dmsd, mmsd, ca, cb, cc;
  wire [23:0] eec;
  wire [1:0] med;
  wire       evld, msoe, cs, we, thin, off, isaoe;
  wire [7:0] msd = msoe ? dmsd : mmsd;
  integer    num_errors = 0, tests_run = 0, m;
  always #2 clk = ~clk;
  jcr_config_regs #(.POR_CYCLES(4)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_strap_a(sa),
    .i_strap_b(sb), .i_strap_c(sc), .i_serial_rom_config_select(sel), .i_ee_valid(evld),
    .i_ee_cfg_a(eec[7:0]), .i_ee_cfg_b(eec[15:8]), .i_ee_cfg_c(eec[23:16]), .i_io_addr(ioa),
    .i_io_wdata(wd), .i_io_wr(iow), .i_io_rd(ior), .i_io_base(10'h300), .o_io_rdata(rdat),
    .i_mem_addr(ma), .i_mem_rd(mr), .i_mem_wr(mw), .i_isa_wdata(wd), .o_isa_rdata(isad),
    .o_isa_rdata_oe(isaoe), .i_msd(msd), .o_msd(dmsd), .o_msd_oe(msoe), .o_strap_pulldown_en(),
    .o_rom_cs(cs), .o_rom_we(we), .i_low_power_request(lp), .o_media_sel(med), .o_thin(thin),
    .o_bus_outputs_disabled(off), .o_cfg_a(ca), .o_cfg_b(cb), .o_cfg_c(cc));
  jcr_far_model #(.EE_A(EA), .EE_B(EB), .EE_C(EC)) mdl (.i_clk(clk), .i_rst_n(rst_n),
    .i_cs(cs), .i_drv(msoe), .i_addr(ma[7:0]), .o_ee_valid(evld), .o_ee_cfg(eec), .o_msd(mmsd));
  task chk(input [7:0] g, e);
    tests_run++;
    if (g !== e) begin num_errors++; $display("BAD %0t got %h want %h", $time, g, e); end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    @(posedge clk) {ioa, wd, iow} <= {a, d, 1'b1};
    @(posedge clk) iow <= 1'b0;
    #1;
  endtask
  task rd(input [9:0] a, input [7:0] e);
    @(posedge clk) {ioa, ior} <= {a, 1'b1};
    @(posedge clk) ior <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task mem(input r, w, input [19:0] a);
    @(posedge clk) {mr, mw, ma} <= {r, w, a};
    #1;
  endtask
  task por(input [7:0] b, c);
    @(posedge clk) {rst_n, sb, sc} <= {1'b0, b, c};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task t_regs;
    chk(cb, 8'h80);
    chk(cc, 8'h2A);
    for (m = 0; m < 3; m++) begin
      wr(10'h301, 8'hA0 | m[7:0]);
      chk({5'h00, thin, med}, {5'h00, m == 2, m[1:0]});
    end
    wr(10'h302, 8'hFF);
    wr(10'h30F, 8'hFF);
    rd(10'h302, 8'h2A);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(cb, 8'hA2);
  endtask
  task t_jless;
    rd(10'h278, 8'h01);
    repeat (3) wr(10'h278, 8'h05);
    rd(10'h302, 8'h2A);
    repeat (3) wr(10'h278, 8'h05);
    chk(ca, 8'h01);
    wr(10'h278, 8'h05);
    chk(ca, 8'h05);
    wr(10'h300, 8'h01);
    repeat (4) wr(10'h278, 8'h07);
    chk(ca, 8'h01);
  endtask
  task t_rom;
    mem(1'b1, 1'b0, 20'h0CBFF);
    chk({7'h00, cs}, 8'h01);
    chk(isad, 8'hA5);
    chk({7'h00, isaoe}, 8'h01);
    mem(1'b1, 1'b0, 20'h0C7FF);
    chk({7'h00, cs}, 8'h00);
    for (m = 0; m < 2; m++) begin
      wr(10'h301, m[0] ? 8'hA0 : 8'h80);
      mem(1'b0, 1'b1, 20'h0C800);
      chk({7'h00, we}, m[7:0]);
      mem(1'b0, 1'b0, 20'h0C800);
    end
  endtask
  task t_power;
    por(8'h00, 8'h2A);
    chk(ca, EA);
    chk(cc, EC);
    @(posedge clk) lp <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, off}, 8'h01);
    wr(10'h301, 8'h01);
    chk(cb, EB);
    @(posedge clk) lp <= 1'b0;
    por(8'h80, 8'hAA);
    wr(10'h301, 8'h01);
    chk(cb, 8'h80);
  endtask
  task close_out;
    $display("Errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    por(8'h80, 8'h2A);
    t_regs;
    t_jless;
    t_rom;
    t_power;
    close_out;
  end
endmodule
